// >>> dcef_pkg.sv
// Purpose: shared constants of the dma channel error-flag block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses on the register bus
package dcef_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_CH = 32;
    localparam int NUM_QCH = 8;
    localparam int NUM_TRIG = 3;
    localparam int NUM_Q = 2;
    localparam int QCNT_W = 5;
    localparam int TCC_MAX = 31;
    localparam int TCC_CNT_W = 6;
    localparam int IRQ_W = 3;

    localparam logic [ADDR_W-1:0] OFS_CH_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CH_CLR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_Q_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_Q_CLR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CC_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CC_CLR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_ERROR_REEVALUATE_BIT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_THR = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_QSTAT0 = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_QSTAT1 = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h2C;

    // controller error word, clear word uses the same layout
    localparam int CC_Q0_BIT = 0;
    localparam int CC_TCC_BIT = 16;
    localparam int ERROR_REEVALUATE_BIT_BIT = 0;
    // threshold and queue status field positions
    localparam int THR_STRIDE = 8;
    localparam int QUEUE_STATUS_CNT_LSB = 0;
    localparam int QUEUE_STATUS_WM_LSB = 8;
    localparam int QUEUE_STATUS_THR_BIT = 24;
    // interrupt status bits
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_MISS_BIT = 1;
    localparam int IRQ_CC_BIT = 2;

    localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
    localparam logic [QCNT_W-1:0] THR_RST = 5'h10;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
endpackage

// >>> dcef_missed_tracker.sv
// Purpose: per-channel missed-event detection with sticky flags
// Assumes: event, serviced and null inputs are one-cycle pulses
// Notes: trigger types are tracked as separate pending bits
`timescale 1ns/1ns
`default_nettype none
module dcef_missed_tracker #(
    parameter int CH = 8,
    parameter int TRIG = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [TRIG*CH-1:0] evt,
    input wire logic [CH-1:0] serviced,
    input wire logic [CH-1:0] nullHit,
    input wire logic [CH-1:0] clr,
    output logic [CH-1:0] flags,
    output logic newFlag
);
    logic [TRIG*CH-1:0] pend_q, pend_d;
    logic [CH-1:0] flag_q, flag_d, setVec;

    if (CH < 1 || CH > 32 || TRIG < 1) begin : g_chk
        $error("dcef_missed_tracker: CH or TRIG out of range");
    end

    // pending bits of every trigger type, dropped when serviced
    always_comb begin
        for (int i = 0; i < TRIG*CH; i++) begin
            pend_d[i] = evt[i] | (pend_q[i] & ~serviced[i%CH]);
        end
    end

    for (genvar c = 0; c < CH; c++) begin : g_ch
        logic [TRIG-1:0] hit;
        always_comb begin
            for (int t = 0; t < TRIG; t++) begin
                hit[t] = evt[t*CH+c] & pend_q[t*CH+c]
                    & ~serviced[c];
            end
            setVec[c] = (|hit) | nullHit[c];
            flag_d[c] = setVec[c]
                | (flag_q[c] & ~clr[c]);
        end

        property p_second_evt;
            @(posedge clk) disable iff (!rstN) (|hit) |=> flag_q[c];
        endproperty
        a_second_evt: assert property (p_second_evt)
            else $error("second event did not set missed flag");
        property p_null_hit;
            @(posedge clk) disable iff (!rstN) nullHit[c] |=> flag_q[c];
        endproperty
        a_null_hit: assert property (p_null_hit)
            else $error("null entry did not set missed flag");
        property p_sticky;
            @(posedge clk) disable iff (!rstN)
                flag_q[c] && !clr[c] |=> flag_q[c];
        endproperty
        a_sticky: assert property (p_sticky)
            else $error("missed flag dropped without clear");
        property p_w1c;
            @(posedge clk) disable iff (!rstN)
                clr[c] && !setVec[c] |=> !flag_q[c];
        endproperty
        a_w1c: assert property (p_w1c)
            else $error("write one did not clear missed flag");
        property p_set_wins;
            @(posedge clk) disable iff (!rstN)
                clr[c] && setVec[c] |=> flag_q[c];
        endproperty
        a_set_wins: assert property (p_set_wins)
            else $error("clear beat a simultaneous set");
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pend_q <= '0;
            flag_q <= '0;
        end else begin
            pend_q <= pend_d;
            flag_q <= flag_d;
        end
    end

    assign flags = flag_q;
    assign newFlag = |(setVec & ~flag_q);
endmodule // dcef_missed_tracker
`default_nettype wire

// >>> dcef_err_irq.sv
// Purpose: error interrupt pulse on first error or on evaluate while an error is set
// Assumes: anyErr is the registered or of all error flags
// Notes: the pulse lasts one cycle
`timescale 1ns/1ns
`default_nettype none
module dcef_err_irq (
    input wire logic clk,
    input wire logic rstN,
    input wire logic anyErr,
    input wire logic evalReq,
    output logic errPulse
);
    logic anyPrev_q, anyPrev_d, pulse_q, pulse_d;

    always_comb begin
        anyPrev_d = anyErr;
        pulse_d = (anyErr & ~anyPrev_q)
            | (evalReq & anyErr);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            anyPrev_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            anyPrev_q <= anyPrev_d;
            pulse_q <= pulse_d;
        end
    end

    assign errPulse = pulse_q;

    sequence s_first_err;
        !anyErr ##1 anyErr;
    endsequence
    sequence s_held_err;
        anyErr [*2] ##0 !evalReq;
    endsequence
    property p_first_err;
        @(posedge clk) disable iff (!rstN) s_first_err |=> errPulse;
    endproperty
    a_first_err: assert property (p_first_err)
        else $error("no error pulse on first error");
    property p_no_repeat;
        @(posedge clk) disable iff (!rstN) s_held_err |=> !errPulse;
    endproperty
    a_no_repeat: assert property (p_no_repeat)
        else $error("error pulse while errors stayed set");
    property p_error_reevaluate_bit;
        @(posedge clk) disable iff (!rstN)
            evalReq && anyErr |=> errPulse ##1 (!errPulse || $past(evalReq));
    endproperty
    a_error_reevaluate_bit: assert property (p_error_reevaluate_bit)
        else $error("evaluate did not pulse error interrupt");
    property p_idle;
        @(posedge clk) disable iff (!rstN) !anyErr |=> !errPulse;
    endproperty
    a_idle: assert property (p_idle)
        else $error("error pulse with no error set");
endmodule // dcef_err_irq
`default_nettype wire

// >>> dcef_error_flags.sv
// Purpose: dma channel error flags, clears and error interrupt
// Assumes: all event inputs are synchronous one-cycle pulses
// Notes: apb slave with zero wait states; read data from flops
`timescale 1ns/1ns
`default_nettype none
module dcef_error_flags
    import dcef_pkg::*;
#(
    parameter int TCC_LIMIT = TCC_MAX
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] chanEvtManual,
    input wire logic [NUM_CH-1:0] chanEvtChain,
    input wire logic [NUM_CH-1:0] chanEvtHw,
    input wire logic [NUM_CH-1:0] chanServiced,
    input wire logic [NUM_CH-1:0] chanNullHit,
    input wire logic [NUM_QCH-1:0] quickEvt,
    input wire logic [NUM_QCH-1:0] quickServiced,
    input wire logic [NUM_QCH-1:0] quickNullHit,
    input wire logic [QCNT_W-1:0] queue0Count,
    input wire logic [QCNT_W-1:0] queue1Count,
    input wire logic trIssued,
    input wire logic completionIntEn,
    input wire logic completionChainEn,
    input wire logic tccReturned,
    output logic errPulse,
    output logic irq
);
    if (TCC_LIMIT < 1 || TCC_LIMIT >= (1 << TCC_CNT_W) - 1) begin : g_chk
        $error("dcef_error_flags: TCC_LIMIT out of range");
    end

    localparam logic [TCC_CNT_W-1:0] TCC_LIM = TCC_CNT_W'(TCC_LIMIT);

    // reset release through two flops
    logic rstMeta_q, rstSync_q, rstN;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rstN = rstSync_q;

    // bus decode
    logic setup, access, wrAcc, rdAcc;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAcc = access & pwrite;
    assign rdAcc = access & ~pwrite;

    logic [NUM_CH-1:0] chClr;
    logic [NUM_QCH-1:0] qClr;
    logic [DATA_W-1:0] ccClr;
    logic evalReq, thrWr, maskWr;

    always_comb begin
        chClr = '0;
        qClr = '0;
        ccClr = RST_ZERO;
        if (wrAcc && paddr == OFS_CH_CLR) begin
            chClr = pwdata[NUM_CH-1:0];
        end
        if (wrAcc && paddr == OFS_Q_CLR) begin
            qClr = pwdata[NUM_QCH-1:0];
        end
        if (wrAcc && paddr == OFS_CC_CLR) begin
            ccClr = pwdata;
        end
    end
    assign evalReq = wrAcc && paddr == OFS_ERROR_REEVALUATE_BIT && pwdata[ERROR_REEVALUATE_BIT_BIT];
    assign thrWr = wrAcc && paddr == OFS_THR;
    assign maskWr = wrAcc && paddr == OFS_IRQ_MASK;

    // missed-event trackers
    logic [NUM_CH-1:0] chFlags;
    logic [NUM_QCH-1:0] qFlags;
    logic chNew, qNew;

    dcef_missed_tracker #(
        .CH(NUM_CH),
        .TRIG(NUM_TRIG)
    ) u_chan (
        .clk(clk),
        .rstN(rstN),
        .evt({chanEvtHw, chanEvtChain, chanEvtManual}),
        .serviced(chanServiced),
        .nullHit(chanNullHit),
        .clr(chClr),
        .flags(chFlags),
        .newFlag(chNew)
    );

    dcef_missed_tracker #(
        .CH(NUM_QCH),
        .TRIG(1)
    ) u_quick (
        .clk(clk),
        .rstN(rstN),
        .evt(quickEvt),
        .serviced(quickServiced),
        .nullHit(quickNullHit),
        .clr(qClr),
        .flags(qFlags),
        .newFlag(qNew)
    );

    // queue thresholds, watermarks and threshold errors
    logic [QCNT_W-1:0] qCount [NUM_Q];
    logic [QCNT_W-1:0] thr_q [NUM_Q];
    logic [QCNT_W-1:0] thr_d [NUM_Q];
    logic [QCNT_W-1:0] wm_q [NUM_Q];
    logic [QCNT_W-1:0] wm_d [NUM_Q];
    logic [NUM_Q-1:0] thrx_q, thrx_d, qHit, qErr_q, qErr_d;
    assign qCount[0] = queue0Count;
    assign qCount[1] = queue1Count;

    for (genvar q = 0; q < NUM_Q; q++) begin : g_q
        logic clrQ;
        assign clrQ = ccClr[CC_Q0_BIT+q];
        always_comb begin
            qHit[q] = qCount[q] >= thr_q[q];
            thr_d[q] = thr_q[q];
            if (thrWr) begin
                thr_d[q] = pwdata[q*THR_STRIDE +: QCNT_W];
            end
            wm_d[q] = (qCount[q] > wm_q[q]) ? qCount[q] : wm_q[q];
            if (clrQ) begin
                wm_d[q] = qCount[q];
            end
            thrx_d[q] = qHit[q] | (thrx_q[q] & ~clrQ);
            qErr_d[q] = qHit[q] | (qErr_q[q] & ~clrQ);
        end
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                thr_q[q] <= THR_RST;
                wm_q[q] <= '0;
                thrx_q[q] <= 1'b0;
                qErr_q[q] <= 1'b0;
            end else begin
                thr_q[q] <= thr_d[q];
                wm_q[q] <= wm_d[q];
                thrx_q[q] <= thrx_d[q];
                qErr_q[q] <= qErr_d[q];
            end
        end

        property p_thr_set;
            @(posedge clk) disable iff (!rstN)
                qCount[q] >= thr_q[q] |=> qErr_q[q] && thrx_q[q];
        endproperty
        a_thr_set: assert property (p_thr_set)
            else $error("queue threshold error not set");
        property p_queue_status_clr;
            @(posedge clk) disable iff (!rstN)
                clrQ && !qHit[q] |=> !thrx_q[q] && !qErr_q[q]
                    && wm_q[q] == $past(qCount[q]);
        endproperty
        a_queue_status_clr: assert property (p_queue_status_clr)
            else $error("queue clear left status fields");
    end

    // outstanding completion-code tracking
    logic [TCC_CNT_W-1:0] tccCnt_q, tccCnt_d;
    logic needTcc, tccOver, completion_code_overflow_q, completion_code_overflow_d;
    assign needTcc = trIssued & (completionIntEn | completionChainEn);
    assign tccOver = needTcc & ~tccReturned
        & (tccCnt_q == TCC_LIM);

    always_comb begin
        tccCnt_d = tccCnt_q;
        if (needTcc && !tccReturned && tccCnt_q != TCC_LIM) begin
            tccCnt_d = tccCnt_q + 1'b1;
        end else if (!needTcc && tccReturned && tccCnt_q != '0) begin
            tccCnt_d = tccCnt_q - 1'b1;
        end
        completion_code_overflow_d = tccOver | (completion_code_overflow_q & ~ccClr[CC_TCC_BIT]);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tccCnt_q <= '0;
            completion_code_overflow_q <= 1'b0;
        end else begin
            tccCnt_q <= tccCnt_d;
            completion_code_overflow_q <= completion_code_overflow_d;
        end
    end

    // controller error word
    logic [DATA_W-1:0] ccWord;
    always_comb begin
        ccWord = RST_ZERO;
        ccWord[CC_Q0_BIT +: NUM_Q] = qErr_q;
        ccWord[CC_TCC_BIT] = completion_code_overflow_q;
    end

    // error interrupt
    logic anyErr;
    assign anyErr = (|chFlags) | (|qFlags) | (|ccWord);

    dcef_err_irq u_irq (
        .clk(clk),
        .rstN(rstN),
        .anyErr(anyErr),
        .evalReq(evalReq),
        .errPulse(errPulse)
    );

    // sticky interrupt status, cleared by reading it
    logic [IRQ_W-1:0] irqSt_q, irqSt_d, irqMask_q, irqMask_d;
    logic [IRQ_W-1:0] irqSet, irqRdClr;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;

    always_comb begin
        irqSet = '0;
        irqSet[IRQ_ERR_BIT] = errPulse;
        irqSet[IRQ_MISS_BIT] = chNew | qNew;
        irqSet[IRQ_CC_BIT] = |{qHit & ~qErr_q, tccOver & ~completion_code_overflow_q};
        irqRdClr = '0;
        if (rdAcc && paddr == OFS_IRQ_STATUS) begin
            irqRdClr = prdata_q[IRQ_W-1:0];
        end
        irqSt_d = irqSet | (irqSt_q & ~irqRdClr);
        irqMask_d = maskWr ? pwdata[IRQ_W-1:0] : irqMask_q;
    end

    // read data captured in the setup cycle
    logic [DATA_W-1:0] qstatWord [NUM_Q];
    for (genvar s = 0; s < NUM_Q; s++) begin : g_queue_status
        always_comb begin
            qstatWord[s] = RST_ZERO;
            qstatWord[s][QUEUE_STATUS_CNT_LSB +: QCNT_W] = qCount[s];
            qstatWord[s][QUEUE_STATUS_WM_LSB +: QCNT_W] = wm_q[s];
            qstatWord[s][QUEUE_STATUS_THR_BIT] = thrx_q[s];
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = RST_ZERO;
            pslverr_d = 1'b0;
            case (paddr)
                OFS_CH_FLAGS: prdata_d = DATA_W'(chFlags);
                OFS_Q_FLAGS: prdata_d = DATA_W'(qFlags);
                OFS_CC_FLAGS: prdata_d = ccWord;
                OFS_CH_CLR, OFS_Q_CLR, OFS_CC_CLR, OFS_ERROR_REEVALUATE_BIT: begin
                    prdata_d = RST_ZERO;
                end
                OFS_THR: begin
                    prdata_d[0 +: QCNT_W] = thr_q[0];
                    prdata_d[THR_STRIDE +: QCNT_W] = thr_q[1];
                end
                OFS_QSTAT0: prdata_d = qstatWord[0];
                OFS_QSTAT1: prdata_d = qstatWord[1];
                OFS_IRQ_STATUS: prdata_d = DATA_W'(irqSt_q);
                OFS_IRQ_MASK: prdata_d = DATA_W'(irqMask_q);
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqSt_q <= '0;
            irqMask_q <= IRQ_MASK_RST;
            prdata_q <= RST_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            irqSt_q <= irqSt_d;
            irqMask_q <= irqMask_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = access;
    assign pslverr = pslverr_q & access;
    assign irq = |(irqSt_q & irqMask_q);

    property p_tcc_over;
        @(posedge clk) disable iff (!rstN) tccOver |=> completion_code_overflow_q;
    endproperty
    a_tcc_over: assert property (p_tcc_over)
        else $error("completion-code overflow not flagged");
    property p_cc_hold;
        @(posedge clk) disable iff (!rstN)
            completion_code_overflow_q && !ccClr[CC_TCC_BIT] |=> completion_code_overflow_q;
    endproperty
    a_cc_hold: assert property (p_cc_hold)
        else $error("controller error dropped without clear");
    property p_cc_layout;
        @(posedge clk) disable iff (!rstN)
            setup && paddr == OFS_CC_FLAGS |=>
                prdata == {15'h0000, $past(completion_code_overflow_q), 14'h0000,
                    $past(qErr_q)};
    endproperty
    a_cc_layout: assert property (p_cc_layout)
        else $error("controller error word misplaced");
    property p_quick_read;
        @(posedge clk) disable iff (!rstN)
            setup && paddr == OFS_Q_FLAGS |=>
                prdata[DATA_W-1:NUM_QCH] == '0
                && prdata[NUM_QCH-1:0] == $past(qFlags);
    endproperty
    a_quick_read: assert property (p_quick_read)
        else $error("quick missed flags read wrong");
    property p_reset;
        @(posedge clk) !rstN |-> !errPulse && !irq && !anyErr;
    endproperty
    a_reset: assert property (p_reset)
        else $error("flags or interrupt active in reset");
    property p_status_sticky;
        @(posedge clk) disable iff (!rstN)
            errPulse |=> irqSt_q[IRQ_ERR_BIT];
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("error pulse not recorded in status");
endmodule // dcef_error_flags
`default_nettype wire

// >>> dcef_pkg_end_marker_none.sv
// Purpose: none
// Assumes: none
// Notes: intentionally empty compilation unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> dma_channel_error_flags_tb_top.sv
// Purpose: self-checking bench of the dma channel error-flag block
// Assumes: zero wait state apb slave, errPulse lasts one cycle
// Notes: code counter limit shortened through TCC_LIMIT
`timescale 1ns/1ns
`default_nettype none
module dma_channel_error_flags_tb_top;
    import dcef_pkg::*;
    localparam int LIM = 3;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, errPulse, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd, m;
    logic [NUM_CH-1:0] cMan, cChn, cHw, cSrv, cNul;
    logic [NUM_QCH-1:0] qEvt, qSrv, qNul;
    logic [QCNT_W-1:0] q0Cnt, q1Cnt, t;
    logic trIss, cIe, cCe, tccRet, errSeen;
    int n_mismatch, checked, nPulse, nExp, cyc, c, d;
    dcef_error_flags #(.TCC_LIMIT(LIM)) dcef_error_flags_i (.clk(clk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chanEvtManual(cMan), .chanEvtChain(cChn),
        .chanEvtHw(cHw), .chanServiced(cSrv), .chanNullHit(cNul),
        .quickEvt(qEvt), .quickServiced(qSrv), .quickNullHit(qNul),
        .queue0Count(q0Cnt), .queue1Count(q1Cnt), .trIssued(trIss),
        .completionIntEn(cIe), .completionChainEn(cCe),
        .tccReturned(tccRet), .errPulse(errPulse), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (errPulse === 1'b1) nPulse++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // expected queue status word from count, peak and exceeded flag
    function automatic logic [31:0] qstatExp(input logic [4:0] cnt, pk,
                                             input logic x);
        qstatExp = ({27'h0, cnt} << QUEUE_STATUS_CNT_LSB)
            | ({27'h0, pk} << QUEUE_STATUS_WM_LSB) | ({31'h0, x} << QUEUE_STATUS_THR_BIT);
    endfunction
    task automatic quick(input logic [7:0] e, s, n);
        @(posedge clk);
        qEvt <= e; qSrv <= s; qNul <= n;
        @(posedge clk);
        qEvt <= '0; qSrv <= '0; qNul <= '0;
    endtask
    task automatic chan(input logic [31:0] mn, ch, hw, s, n);
        @(posedge clk);
        cMan <= mn; cChn <= ch; cHw <= hw; cSrv <= s; cNul <= n;
        @(posedge clk);
        cMan <= '0; cChn <= '0; cHw <= '0; cSrv <= '0; cNul <= '0;
    endtask
    task automatic tr(input logic ie, ce, iss, ret);
        @(posedge clk);
        trIss <= iss; cIe <= ie; cCe <= ce; tccRet <= ret;
        @(posedge clk);
        trIss <= 1'b0; cIe <= 1'b0; cCe <= 1'b0; tccRet <= 1'b0;
    endtask
    task automatic rst;
        arst_n <= 1'b0;
        step(16);
        arst_n <= 1'b1;
        step(3);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, trIss, cIe, cCe, tccRet} = '0;
        {cMan, cChn, cHw, cSrv, cNul, qEvt, qSrv, qNul, q0Cnt, q1Cnt} = '0;
        void'($urandom(32'h020e_cae2));
        rst();
        rdChk(OFS_Q_FLAGS, RST_ZERO);
        rdChk(OFS_CC_FLAGS, RST_ZERO);
        rdChk(OFS_THR, {19'h0, THR_RST, 3'h0, THR_RST});
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
        c = $urandom_range(7, 0);
        d = (c + 1) % 8;
        quick(8'h01 << c, 8'h00, 8'h00);
        quick(8'h00, 8'h01 << c, 8'h00);
        quick(8'h01 << c, 8'h00, 8'h00);
        quick(8'h00, 8'h01 << c, 8'h00);
        rdChk(OFS_Q_FLAGS, RST_ZERO);
        quick(8'h01 << c, 8'h00, 8'h00);
        quick(8'h01 << c, 8'h00, 8'h00);
        step(4);
        nExp++;
        rdChk(OFS_Q_FLAGS, 32'h1 << c);
        chk(nPulse, nExp);
        chk({31'h0, irq}, 32'h0000_0001);
        rdChk(OFS_IRQ_STATUS, 32'h0000_0003);
        step(2);
        chk({31'h0, irq}, 32'h0000_0000);
        quick(8'h00, 8'h00, 8'h01 << d);
        step(4);
        rdChk(OFS_Q_FLAGS, (32'h1 << c) | (32'h1 << d));
        chk(nPulse, nExp);
        m = ($urandom & ~(32'h1 << c)) | (32'h1 << d);
        apb(1'b1, OFS_Q_CLR, m);
        rdChk(OFS_Q_FLAGS, 32'h1 << c);
        apb(1'b1, OFS_CC_FLAGS, 32'hffff_ffff);
        rdChk(OFS_Q_FLAGS, 32'h1 << c);
        apb(1'b1, OFS_Q_CLR, 32'h1 << c);
        rdChk(OFS_Q_FLAGS, RST_ZERO);
        quick(8'h00, 8'h00, 8'h01 << c);
        step(4);
        nExp++;
        chk(nPulse, nExp);
        apb(1'b1, OFS_ERROR_REEVALUATE_BIT, 32'h0000_0000);
        step(2);
        chk(nPulse, nExp);
        apb(1'b1, OFS_ERROR_REEVALUATE_BIT, 32'h0000_0001);
        step(2);
        nExp++;
        chk(nPulse, nExp);
        apb(1'b1, OFS_Q_CLR, 32'h0000_00ff);
        c = $urandom_range(31, 0);
        d = (c + 5) % 32;
        chan(32'h1 << c, 32'h1 << c, 32'h1 << c, '0, '0);
        chan('0, '0, '0, 32'h1 << c, '0);
        chan(32'h1 << c, '0, '0, '0, '0);
        chan('0, 32'h1 << c, '0, '0, '0);
        rdChk(OFS_CH_FLAGS, RST_ZERO);
        chan(32'h1 << c, '0, '0, '0, 32'h1 << d);
        step(4);
        nExp++;
        rdChk(OFS_CH_FLAGS, (32'h1 << c) | (32'h1 << d));
        chk(nPulse, nExp);
        apb(1'b1, OFS_CH_CLR, 32'h1 << c);
        rdChk(OFS_CH_FLAGS, 32'h1 << d);
        apb(1'b1, OFS_CH_CLR, 32'hffff_ffff);
        rdChk(OFS_CH_FLAGS, RST_ZERO);
        apb(1'b1, OFS_IRQ_MASK, RST_ZERO);
        apb(1'b0, OFS_IRQ_STATUS, RST_ZERO);
        t = 5'($urandom_range(20, 2));
        apb(1'b1, OFS_THR, {19'h0, 5'h1f, 3'h0, t});
        @(posedge clk) q0Cnt <= t - 5'h01;
        step(3);
        rdChk(OFS_CC_FLAGS, RST_ZERO);
        @(posedge clk) q0Cnt <= t;
        @(posedge clk) q0Cnt <= '0;
        step(3);
        nExp++;
        rdChk(OFS_CC_FLAGS, 32'h0000_0001);
        rdChk(OFS_QSTAT0, qstatExp(5'h00, t, 1'b1));
        chk(nPulse, nExp);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
        rdChk(OFS_IRQ_MASK, 32'h0000_0004);
        step(2);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, OFS_CC_CLR, 32'h0001_0002);
        rdChk(OFS_CC_FLAGS, 32'h0000_0001);
        apb(1'b1, OFS_CC_CLR, 32'h0000_0001);
        rdChk(OFS_CC_FLAGS, RST_ZERO);
        rdChk(OFS_QSTAT0, RST_ZERO);
        // queue 1 reaches its threshold only at the clear's access edge
        fork
            apb(1'b1, OFS_CC_CLR, 32'h0000_0002);
            begin
                step(2);
                q1Cnt <= 5'h1f;
                step(1);
                q1Cnt <= '0;
            end
        join
        nExp++;
        rdChk(OFS_CC_FLAGS, 32'h0000_0002);
        rdChk(OFS_QSTAT1, qstatExp(5'h00, 5'h1f, 1'b1));
        apb(1'b1, OFS_CC_CLR, 32'h0000_0002);
        rdChk(OFS_QSTAT1, RST_ZERO);
        repeat (4) tr(1'b0, 1'b0, 1'b1, 1'b0);
        tr(1'b1, 1'b0, 1'b1, 1'b0);
        tr(1'b0, 1'b1, 1'b1, 1'b0);
        tr(1'b1, 1'b1, 1'b1, 1'b0);
        tr(1'b0, 1'b0, 1'b0, 1'b1);
        tr(1'b1, 1'b0, 1'b1, 1'b0);
        rdChk(OFS_CC_FLAGS, RST_ZERO);
        tr(1'b0, 1'b1, 1'b1, 1'b0);
        step(3);
        nExp++;
        rdChk(OFS_CC_FLAGS, 32'h0001_0000);
        chk(nPulse, nExp);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk({31'h0, errSeen}, 32'h0000_0001);
        quick(8'h00, 8'h00, 8'hff);
        rst();
        rdChk(OFS_Q_FLAGS, RST_ZERO);
        rdChk(OFS_CC_FLAGS, RST_ZERO);
        chk({31'h0, irq}, 32'h0000_0000);
        stop_test();
    end
endmodule // dma_channel_error_flags_tb_top
`default_nettype wire
